// File: sit_pkg.sv
// sit_pkg: register map, field positions, reset values and prescale limits
// assumes: shared by the timer top, its prescaler and its bench
package sit_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices on the plain register port
   localparam logic [2:0] SIT_ADDR_CTRL = 3'h0;
   localparam logic [2:0] SIT_ADDR_COUNT = 3'h1;
   localparam logic [2:0] SIT_ADDR_PERIOD = 3'h2;
   localparam logic [2:0] SIT_ADDR_STATUS = 3'h3;
   localparam logic [2:0] SIT_ADDR_IRQ_EN = 3'h4;
   localparam logic [2:0] SIT_ADDR_PRIO = 3'h5;

   ////////////////////////////////////////////////////////////////////////////
   // timer_control_word field positions
   localparam int SIT_BIT_ON = 15;
   localparam int SIT_BIT_GATE = 6;
   localparam int SIT_BIT_PS_HI = 5;
   localparam int SIT_BIT_PS_LO = 4;
   localparam int SIT_BIT_SYNC = 2;
   localparam int SIT_BIT_SRC = 1;

   // status and irq enable bit positions
   localparam int SIT_EV_MATCH = 0;
   localparam int SIT_EV_GATE = 1;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] SIT_RST_CTRL = 16'h0000;
   localparam logic [15:0] SIT_RST_COUNT = 16'h0000;
   localparam logic [15:0] SIT_RST_PERIOD = 16'hFFFF;
   localparam logic [1:0] SIT_RST_EVENTS = 2'h0;
   localparam logic [2:0] SIT_RST_PRIO = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // prescaler terminal counts per prescale_select code
   localparam logic [7:0] SIT_PS_LIMIT_0 = 8'h00;
   localparam logic [7:0] SIT_PS_LIMIT_1 = 8'h07;
   localparam logic [7:0] SIT_PS_LIMIT_2 = 8'h3F;
   localparam logic [7:0] SIT_PS_LIMIT_3 = 8'hFF;

endpackage

// File: sit_presc_if.sv
// sit_presc_if: link between the timer top and its prescaler
// assumes: both ends run on the same clock
`timescale 1ns/1ps
interface sit_presc_if;
   logic tick_in;
   logic clear;
   logic [1:0] sel;
   logic tick_out;
   // timer side drives the input ticks and ratio
   modport ctrl (output tick_in, output clear, output sel, input tick_out);
   // divider side returns the prescaled tick
   modport div (input tick_in, input clear, input sel, output tick_out);
endinterface

// File: sit_sync.sv
// sit_sync: three-stage pin synchroniser with agreement filter and edges
// assumes: pin is asynchronous to clk; edges are one-cycle pulses
`timescale 1ns/1ps
module sit_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // raw pin
   input wire logic pin_in,
   // filtered level and edges
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1;
   logic s2;
   logic s3;
   wire agree = (s2 == s3);

   // shift chain, level moves only when stages two and three agree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         level <= agree ? s3 : level;
         rise <= agree && s3 && !level;
         fall <= agree && !s3 && level;
      end
   end
endmodule

// File: sit_prescaler.sv
// sit_prescaler: divides the input tick by 1, 8, 64 or 256
// assumes: clear restarts the division phase
`timescale 1ns/1ps
module sit_prescaler (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // tick link
   sit_presc_if.div link
);
   import sit_pkg::*;

   logic [7:0] cnt;
   logic [7:0] limit;
   // a phase left above a smaller new limit ticks at once instead of wrapping round
   wire at_limit = (cnt >= limit);

   // terminal count for the selected ratio
   always_comb begin
      case (link.sel)
         2'h0: limit = SIT_PS_LIMIT_0;
         2'h1: limit = SIT_PS_LIMIT_1;
         2'h2: limit = SIT_PS_LIMIT_2;
         default: limit = SIT_PS_LIMIT_3;
      endcase
   end

   assign link.tick_out = link.tick_in && at_limit && !link.clear;

   // phase counter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 8'h00;
      end else if (link.clear || (link.tick_in && at_limit)) begin
         cnt <= 8'h00;
      end else if (link.tick_in) begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// File: sit_timer.sv
// sit_timer: 16-bit interval timer / counter with period match and gating
// assumes: one 100 MHz clock; pins are asynchronous; registers via plain port
// How it works
// - a 16-bit up-counter serves as interval timer, counter or clock base
// - modes: internal timer, synced external counter, async external counter
// - interrupt on period match, and on gate falling edge when gating
// - counting does not depend on any cpu idle or sleep state
// - timer_on_bit set enables counting, cleared keeps the count halted
// - prescale_select picks the input clock divide ratio
// - clock_source_select picks clock; gate_accumulate_enable enables gated counting of the internal clock
// - external_sync_select chooses synchronised or asynchronous external counting
// - irq only when timer_irq_enable set; priority from timer_irq_priority
`timescale 1ns/1ps
module sit_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic [2:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [15:0] bus_rdata,
   // external pins
   input wire logic ext_clk_pin,
   input wire logic gate_pin,
   // interrupt
   output logic irq,
   output logic [2:0] irq_priority
);
   import sit_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [15:0] ctrl;
   logic [15:0] count;
   logic [15:0] period;
   logic [1:0] status;
   logic [1:0] irq_en;
   logic [2:0] prio;
   // synchronised pin levels and their one-cycle edge pulses
   logic ext_rise_d;
   logic gate_lvl;
   logic gate_fall;
   logic ext_lvl;
   logic ext_rise;

   // ratio, clear and ticks travel together to the divider
   sit_presc_if presc ();

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   sit_sync u_ext_sync (
      .clk(clk),
      .rstn(rstn),
      .pin_in(ext_clk_pin),
      .level(ext_lvl),
      .rise(ext_rise),
      .fall()
   );

   sit_sync u_gate_sync (
      .clk(clk),
      .rstn(rstn),
      .pin_in(gate_pin),
      .level(gate_lvl),
      .rise(),
      .fall(gate_fall)
   );

   // divider between the selected tick source and the counter
   sit_prescaler u_presc (
      .clk(clk),
      .rstn(rstn),
      .link(presc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // control field decode
   wire timer_on_bit = ctrl[SIT_BIT_ON];
   wire gate_accumulate_enable = ctrl[SIT_BIT_GATE];
   wire [1:0] prescale_select = ctrl[SIT_BIT_PS_HI:SIT_BIT_PS_LO];
   wire external_sync_select = ctrl[SIT_BIT_SYNC];
   wire clock_source_select = ctrl[SIT_BIT_SRC];
   wire gated_internal = gate_accumulate_enable && !clock_source_select;

   // register write decode
   wire wr_ctrl = bus_wr && (bus_addr == SIT_ADDR_CTRL);
   wire wr_count = bus_wr && (bus_addr == SIT_ADDR_COUNT);
   wire wr_period = bus_wr && (bus_addr == SIT_ADDR_PERIOD);
   wire wr_status = bus_wr && (bus_addr == SIT_ADDR_STATUS);
   wire wr_irq_en = bus_wr && (bus_addr == SIT_ADDR_IRQ_EN);
   wire wr_prio = bus_wr && (bus_addr == SIT_ADDR_PRIO);

   ////////////////////////////////////////////////////////////////////////////
   // mode tick select
   // sync or async edge
   // the synced path re-aligns the edge one more stage to the system clock;
   // the async path takes the filtered edge as soon as it is seen
   wire ext_tick = external_sync_select ? ext_rise_d : ext_rise;
   wire int_tick = gated_internal ? gate_lvl : 1'b1;
   wire raw_tick = clock_source_select ? ext_tick : int_tick;

   // clearing the divider while off makes a restart wait a full ratio
   // halted when off
   assign presc.tick_in = timer_on_bit && raw_tick;
   assign presc.clear = !timer_on_bit;
   assign presc.sel = prescale_select;
   wire tick = presc.tick_out;

   // the compare is live every cycle; only a prescaled tick acts on it
   // period compare
   wire match = (count == period);
   wire ev_match = tick && match;
   wire ev_gate = timer_on_bit && gated_internal && gate_fall;
   wire [1:0] events = {ev_gate, ev_match};

   // no power state input
   // a software write to the count wins over a tick in the same cycle
   wire [15:0] next_count = wr_count ? bus_wdata :
                            ev_match ? 16'h0000 :
                            tick ? count + 16'h0001 : count;

   // an event in the cycle of a write-one clear keeps its flag set
   // sticky set wins
   wire [1:0] next_status = (status & ~(wr_status ? bus_wdata[1:0] : 2'h0)) | events;

   ////////////////////////////////////////////////////////////////////////////
   // read mux, unmapped addresses read zero
   // narrow registers read zero in their upper bits
   wire [15:0] rd_mux = (bus_addr == SIT_ADDR_CTRL) ? ctrl :
                        (bus_addr == SIT_ADDR_COUNT) ? count :
                        (bus_addr == SIT_ADDR_PERIOD) ? period :
                        (bus_addr == SIT_ADDR_STATUS) ? {14'h0000, status} :
                        (bus_addr == SIT_ADDR_IRQ_EN) ? {14'h0000, irq_en} :
                        (bus_addr == SIT_ADDR_PRIO) ? {13'h0000, prio} : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   // ctrl keeps all sixteen written bits, unused ones read back as written
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl <= SIT_RST_CTRL;
         period <= SIT_RST_PERIOD;
         irq_en <= SIT_RST_EVENTS;
         prio <= SIT_RST_PRIO;
      end else begin
         if (wr_ctrl) begin
            ctrl <= bus_wdata;
         end
         if (wr_period) begin
            period <= bus_wdata;
         end
         if (wr_irq_en) begin
            irq_en <= bus_wdata[1:0];
         end
         if (wr_prio) begin
            prio <= bus_wdata[2:0];
         end
      end
   end

   // counter, status and edge alignment stage
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= SIT_RST_COUNT;
         status <= SIT_RST_EVENTS;
         ext_rise_d <= 1'b0;
      end else begin
         count <= next_count;
         status <= next_status;
         ext_rise_d <= ext_rise;
      end
   end

   // read data one cycle after the read strobe, zero otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_rdata <= 16'h0000;
      end else begin
         bus_rdata <= bus_rd ? rd_mux : 16'h0000;
      end
   end

   // a plain level, so a masked flag can still be polled
   // enabled irq
   assign irq = |(status & irq_en);
   assign irq_priority = prio;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   // all checks share the system clock and are off while reset is low
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_halt_holds_count: assert property (
      (!timer_on_bit && !wr_count) |=> $stable(count))
      else $error("count moved while timer off");

   a_match_wraps_zero: assert property (
      (ev_match && !wr_count) |=> (count == 16'h0000))
      else $error("count not cleared on period match");

   a_match_sets_flag: assert property (
      (tick && count == period) |=> status[SIT_EV_MATCH])
      else $error("match flag not set");

   a_count_steps_one: assert property (
      (tick && !match && !wr_count) |=> (count == $past(count) + 16'h0001))
      else $error("count did not step by one");

   a_gate_low_stops: assert property (
      (timer_on_bit && gated_internal && !gate_lvl && !wr_count && !wr_ctrl)
      |=> $stable(count))
      else $error("count moved with gate low");

   a_gate_fall_flag: assert property (
      (timer_on_bit && gated_internal && gate_fall) |=> status[SIT_EV_GATE])
      else $error("gate fall flag not set");

   a_irq_needs_enable: assert property (
      $rose(irq) |-> ($past(ev_match) || $past(ev_gate) || $past(wr_irq_en)))
      else $error("irq rose without an enabled event");

   a_irq_follows_flag: assert property (
      (ev_match && irq_en[SIT_EV_MATCH] && !wr_irq_en) |=> irq)
      else $error("enabled match did not raise irq");

   a_prescale_unity: assert property (
      (timer_on_bit && prescale_select == 2'h0 && !wr_ctrl && raw_tick) |-> tick)
      else $error("unity prescale dropped a tick");

   a_prescale_eight: assert property (
      (tick && prescale_select == 2'h1 && !clock_source_select && !gated_internal
       && !wr_ctrl) |=> !tick [*7])
      else $error("divide by eight ticked early");

   a_sync_delays_edge: assert property (
      (clock_source_select && external_sync_select && ext_rise) |-> !ext_tick)
      else $error("synced mode took edge without alignment");

   a_w1c_clears: assert property (
      (wr_status && bus_wdata[1:0] == 2'h3 && events == 2'h0) |=> (status == 2'h0))
      else $error("status did not clear on write one");

   a_read_period: assert property (
      (bus_rd && bus_addr == SIT_ADDR_PERIOD) |=> (bus_rdata == $past(period)))
      else $error("period read back wrong");

   ////////////////////////////////////////////////////////////////////////////
   // pins and modes: a filtered edge reaches the counter at a fixed lag
   // async mode takes the edge in the cycle it is seen, sync mode one later

   a_async_edge_now: assert property (
      (timer_on_bit && clock_source_select && !external_sync_select
       && prescale_select == 2'h0 && ext_rise) |-> tick)
      else $error("async edge not counted at once");

   a_sync_edge_next: assert property (
      (timer_on_bit && clock_source_select && external_sync_select
       && prescale_select == 2'h0 && ext_rise && !wr_ctrl) |=> tick)
      else $error("sync edge not counted one cycle later");

   a_ext_no_free_tick: assert property (
      (clock_source_select && !ext_rise && !ext_rise_d) |-> !tick)
      else $error("external mode ticked without a pin edge");

   a_gate_high_counts: assert property (
      (timer_on_bit && gated_internal && gate_lvl && prescale_select == 2'h0) |-> tick)
      else $error("gate high did not let the count run");

   a_off_no_tick: assert property (
      !timer_on_bit |-> !tick)
      else $error("tick while timer off");

   ////////////////////////////////////////////////////////////////////////////
   // register port: writes land at the strobe edge, reads answer one cycle on

   a_ctrl_write: assert property (
      wr_ctrl |=> (ctrl == $past(bus_wdata)))
      else $error("control write did not land");

   a_count_write: assert property (
      wr_count |=> (count == $past(bus_wdata)))
      else $error("count write did not land");

   a_period_write: assert property (
      wr_period |=> (period == $past(bus_wdata)))
      else $error("period write did not land");

   a_read_count: assert property (
      (bus_rd && bus_addr == SIT_ADDR_COUNT) |=> (bus_rdata == $past(count)))
      else $error("count read back wrong");

   a_status_read: assert property (
      (bus_rd && bus_addr == SIT_ADDR_STATUS) |=> (bus_rdata == {14'h0000, $past(status)}))
      else $error("status read back wrong");

   a_unmapped_zero: assert property (
      (bus_rd && bus_addr > SIT_ADDR_PRIO) |=> (bus_rdata == 16'h0000))
      else $error("unmapped index did not read zero");

   a_rdata_idle_zero: assert property (
      !bus_rd |=> (bus_rdata == 16'h0000))
      else $error("read data not zero outside a read");

   ////////////////////////////////////////////////////////////////////////////
   // interrupt: flags stay until software writes a one, enables gate the line

   a_match_sticky: assert property (
      (status[SIT_EV_MATCH] && !(wr_status && bus_wdata[SIT_EV_MATCH]))
      |=> status[SIT_EV_MATCH])
      else $error("match flag dropped without a clear");

   a_gate_flag_clear: assert property (
      (wr_status && bus_wdata[SIT_EV_GATE] && !ev_gate) |=> !status[SIT_EV_GATE])
      else $error("gate flag did not clear on write one");

   a_irq_en_write: assert property (
      wr_irq_en |=> ({14'h0000, irq_en} == ($past(bus_wdata) & 16'h0003)))
      else $error("irq enable write did not land");

   a_prio_write: assert property (
      wr_prio |=> ({13'h0000, irq_priority} == ($past(bus_wdata) & 16'h0007)))
      else $error("priority write did not land");

   c_period_match: cover property (ev_match && irq_en[SIT_EV_MATCH]);
   c_gate_event: cover property (ev_gate);
   c_ext_async: cover property (clock_source_select && !external_sync_select && tick);
   c_ext_sync: cover property (clock_source_select && external_sync_select && tick);
   c_prescale_max: cover property (tick && prescale_select == 2'h3);

endmodule

// File: sit_pins_model.sv
// sit_pins_model: far side of the timer, drives the count clock and gate pins
// assumes: commanded by the bench between clock edges; pins rest low when idle
`timescale 1ns/1ps
module sit_pins_model (
   // clock
   input wire logic clk,
   // pins toward the timer
   output logic ext_clk_pin,
   output logic gate_pin
);
   // both pins rest low outside bursts
   initial begin
      ext_clk_pin = 1'b0;
      gate_pin = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // external count pulses
   // each level held at least three clocks so the filter keeps it
   task automatic pulses(input int n, input int half);
      for (int i = 0; i < 2 * n; i++) begin
         ext_clk_pin <= ~ext_clk_pin;
         repeat (half < 3 ? 3 : half) @(posedge clk);
      end
   endtask

   task automatic set_gate(input logic v);
      gate_pin <= v;
   endtask
endmodule

// File: sit_timer_tb.sv
// sit_timer_tb: self-checking bench for the interval timer
// assumes: pin model on the far side; one 100 MHz clock
`timescale 1ns/1ps
module sit_timer_tb;
   import sit_pkg::*;
   localparam logic [15:0] CTRL_ON = 16'h8000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] bus_addr = 3'h0;
   logic [15:0] bus_wdata = 16'h0000;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [15:0] bus_rdata;
   logic ext_clk_pin;
   logic gate_pin;
   logic irq;
   logic [2:0] irq_priority;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   // clock and cycle count
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   // block and its far side
   sit_timer uut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_clk_pin(ext_clk_pin),
      .gate_pin(gate_pin), .irq(irq), .irq_priority(irq_priority));
   sit_pins_model pins (.clk(clk), .ext_clk_pin(ext_clk_pin), .gate_pin(gate_pin));

   ////////////////////////////////////////////////////////////////////////////
   // reporting
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // register port cycles
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   // bounded wait for the interrupt line
   task automatic wait_irq();
      int k = 0;
      #1;
      while (irq !== 1'b1 && k < 2000) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k == 2000) begin
         check(16'h0000, 16'h0001, "irq timeout");
         give_verdict();
      end
   endtask

   // cycles between two successive matches
   task automatic measure(output int gap);
      int t0;
      wait_irq();
      t0 = cyc;
      wr(SIT_ADDR_STATUS, 16'h0001);
      wait_irq();
      gap = cyc - t0;
      wr(SIT_ADDR_STATUS, 16'h0001);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic test_reset();
      logic [15:0] d;
      logic [15:0] exp [8];
      exp = '{SIT_RST_CTRL, SIT_RST_COUNT, SIT_RST_PERIOD, 16'h0000, 16'h0000, 16'h0000,
         16'h0000, 16'h0000};
      check({15'h0, irq}, 16'h0000, "irq after reset");
      wr(3'h7, 16'hFFFF);
      for (int a = 0; a < 8; a++) begin
         rd(3'(a), d);
         check(d, exp[a], "reset value");
      end
      wr(SIT_ADDR_COUNT, 16'h1234);
      repeat (20) @(posedge clk);
      rd(SIT_ADDR_COUNT, d);
      check(d, 16'h1234, "halted count");
      $display("test reset done");
   endtask

   task automatic test_prescale();
      logic [15:0] d;
      int gap;
      int ratio [4] = '{1, 8, 64, 256};
      wr(SIT_ADDR_IRQ_EN, 16'h0001);
      wr(SIT_ADDR_PERIOD, 16'h0003);
      for (int ps = 0; ps < 4; ps++) begin
         wr(SIT_ADDR_CTRL, 16'h0000);
         wr(SIT_ADDR_COUNT, 16'h0000);
         wr(SIT_ADDR_STATUS, 16'h0003);
         wr(SIT_ADDR_CTRL, CTRL_ON | 16'(ps << SIT_BIT_PS_LO));
         measure(gap);
         check(16'(gap), 16'(4 * ratio[ps]), "match interval");
      end
      wr(SIT_ADDR_IRQ_EN, 16'h0000);
      repeat (1100) @(posedge clk);
      #1;
      check({15'h0, irq}, 16'h0000, "masked irq");
      rd(SIT_ADDR_STATUS, d);
      check({15'h0, d[0]}, 16'h0001, "match flag sticky");
      for (int p = 0; p < 8; p++) begin
         wr(SIT_ADDR_PRIO, 16'(p));
         repeat (2) @(posedge clk);
         #1;
         check({13'h0, irq_priority}, 16'(p), "priority");
      end
      $display("test prescale done");
   endtask

   task automatic test_ext();
      logic [15:0] d;
      for (int s = 0; s < 2; s++) begin
         wr(SIT_ADDR_CTRL, 16'h0000);
         wr(SIT_ADDR_COUNT, 16'h0000);
         wr(SIT_ADDR_STATUS, 16'h0003);
         wr(SIT_ADDR_CTRL, CTRL_ON | 16'(1 << SIT_BIT_SRC) | 16'(s << SIT_BIT_SYNC));
         pins.pulses(3, 4);
         repeat (10) @(posedge clk);
         rd(SIT_ADDR_COUNT, d);
         check(d, 16'h0003, "external count");
         pins.pulses(1, 4);
         repeat (10) @(posedge clk);
         rd(SIT_ADDR_COUNT, d);
         check(d, 16'h0000, "external wrap");
         rd(SIT_ADDR_STATUS, d);
         check(d, 16'h0001, "external match");
      end
      $display("test external done");
   endtask

   task automatic test_gate();
      logic [15:0] d;
      wr(SIT_ADDR_CTRL, 16'h0000);
      wr(SIT_ADDR_PERIOD, 16'hFFFF);
      wr(SIT_ADDR_COUNT, 16'h0000);
      wr(SIT_ADDR_STATUS, 16'h0003);
      wr(SIT_ADDR_IRQ_EN, 16'h0002);
      wr(SIT_ADDR_CTRL, CTRL_ON | 16'(1 << SIT_BIT_GATE));
      repeat (20) @(posedge clk);
      rd(SIT_ADDR_COUNT, d);
      check(d, 16'h0000, "gate low holds");
      pins.set_gate(1'b1);
      repeat (50) @(posedge clk);
      pins.set_gate(1'b0);
      repeat (10) @(posedge clk);
      rd(SIT_ADDR_COUNT, d);
      check({15'h0, d >= 16'd48 && d <= 16'd52}, 16'h0001, "gated count");
      check({15'h0, irq}, 16'h0001, "gate fall irq");
      rd(SIT_ADDR_STATUS, d);
      check(d, 16'h0002, "gate fall flag");
      wr(SIT_ADDR_CTRL, CTRL_ON);
      wr(SIT_ADDR_STATUS, 16'h0003);
      pins.set_gate(1'b1);
      repeat (10) @(posedge clk);
      pins.set_gate(1'b0);
      repeat (10) @(posedge clk);
      rd(SIT_ADDR_STATUS, d);
      check(d, 16'h0000, "gate ignored");
      $display("test gate done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      test_reset();
      test_prescale();
      test_ext();
      test_gate();
      give_verdict();
   end
endmodule
